// *** rtl/safe_regs_map.vh ***
`ifndef SAFE_REGS_MAP_VH
`define SAFE_REGS_MAP_VH
// register indices as printed; byte address is four times the index
`define SAFE_IDX_TRIM        8'h42
`define SAFE_IDX_PATH        8'h43
`define SAFE_IDX_CHGAIN      8'h55
// trim register fields
`define SAFE_BIT_INT_BUF     7
`define SAFE_BIT_IND_EN      6
`define SAFE_VREF_HI         5
`define SAFE_VREF_LO         4
`define SAFE_GAIN_HI         1
`define SAFE_GAIN_LO         0
// trim reset: upper fields 15:10 = 0x07, 9:8 = 0, bit7 0, bit6 0, vref 3, rsvd 2, gain 0
`define SAFE_TRIM_RST        16'h1C38
`define SAFE_PATH_RST        16'hADA5
`define SAFE_CHGAIN_RST      16'h0000
// path flag resets follow the reset path code
`define SAFE_FULL_FLAG_RST   1'h1
`define SAFE_TIA_FLAG_RST    1'h0
`define SAFE_RSVD_FLAG_RST   1'h0
// documented path codes
`define SAFE_PATH_FULL       16'hADA5
`define SAFE_PATH_TIA_BUF    16'hAE65
`define SAFE_PATH_TIA_NOBUF  16'hB065
// ahb transfer type
`define SAFE_HTRANS_NONSEQ   2'h2
`endif

// *** rtl/safe_gain_sel.v ***
`timescale 1ns/1ps
// picks per-channel gain codes from the shared or the individual source
module safe_gain_sel (
  input  wire       per_channel_en,
  input  wire [1:0] common_gain,
  input  wire [5:0] channel_gains,
  output wire [7:0] gain_codes
);
  // channel 1 always follows the shared field; 2..4 switch source
  assign gain_codes[1:0] = common_gain; // RULE2 RULE3
  assign gain_codes[7:2] = per_channel_en ? channel_gains : {3{common_gain}}; // RULE2 RULE3
endmodule // safe_gain_sel

// *** rtl/safe_regs.v ***
`timescale 1ns/1ps
`include "safe_regs_map.vh"
// slot a front-end configuration registers
//
// bus view
//   single-word ahb-lite slave, zero wait states, never errors
//   the address phase is taken when hsel, hready and nonseq meet
//   a write lands at the edge that closes its data phase
//   a read is looked up in the address phase and held on hrdata
//   hrdata keeps standing until the next read address phase
//   hsize is not decoded; every access is treated as one word
//   haddr bits above 9 are not decoded, so the map repeats
//   upper halves of written words are dropped, reads return zero there
//
// register map, word index times four is the byte address
//   slot_a_integrator_gain_trim  trim: integrator mode, integrator gain, buffer select,
//         per-channel enable, reference, reserved pair, gain code
//   0x43  path connection code, all sixteen bits kept
//   0x55  per-channel gain codes for channels two to four
//   any other index reads zero and swallows writes
//
// trim field layout
//   15:10 integrator mode, reset 0x07
//   9:8   integrator gain, reset 0
//   7     integrator used as buffer, reset 0
//   6     per-channel gain enable, reset 0
//   5:4   transimpedance reference, reset 3
//   3:2   reserved pair, reset 2, stored and read back as written
//   1:0   transimpedance gain code, reset 0
//
// path codes
//   full analog path, tia straight to adc with buffer,
//   tia straight to adc without buffer; everything else reserved
//   keeping the buffer bit consistent with the path is left to
//   software; the block flags the mode and never overrides it
//
// outputs are plain levels; nothing here pulses or counts
// the analog side may read them at any time, they change only
// at the edge that closes a write data phase or on reset
//
// Contract
// RULE1 - trim bit 7 resets to 0; setting 1 makes integrator a buffer
// RULE2 - bit 6 set: ch1 gain from trim 1:0, ch2-4 from 0x55 bits 5:0
// RULE3 - bit 6 clear: trim gain bits 1:0 apply to all four channels
// RULE4 - reference field bits 5:4 resets to 3, selects one of four voltages
// RULE5 - gain field bits 1:0 resets to 0, selects 200k/100k/50k/25k
// RULE6 - 0x43 is a 16-bit path code, reset 0xADA5 full analog path
// RULE7 - software using 0xAE65 also sets trim bit 7 and 0x58 bit 7
// RULE8 - software uses 0xB065 for tia-adc mode with buffer bit clear
// RULE9 - fields read back last write and drive static levels until changed
module safe_regs (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire        slot_a_integrator_buffer_select,
  output wire        slot_a_per_channel_gain_enable,
  output wire [1:0]  slot_a_transimpedance_reference,
  output wire [1:0]  slot_a_transimpedance_gain_code,
  output wire [7:0]  slot_a_channel_gain_codes,
  output wire [5:0]  slot_a_integrator_mode,
  output wire [1:0]  slot_a_integrator_gain,
  output wire [15:0] slot_a_path_connection_code,
  output wire        full_analog_path_mode,
  output wire        slot_a_tia_adc_mode,
  output wire        slot_a_path_reserved
);
  reg  [15:0] slot_a_integrator_gain_trim_reg;
  reg  [15:0] slot_a_path_connection_reg;
  reg  [15:0] slot_a_channel_gain_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_idx_reg;
  reg  [31:0] rdata_reg;
  reg  [15:0] slot_a_path_connection_next;
  reg         full_mode_reg;
  reg         tia_mode_reg;
  reg         rsvd_reg;
  wire        access;
  wire [7:0]  idx;

  // path code classifiers, shared by the flag logic
  function path_is_full;
    input [15:0] code;
    begin
      path_is_full = (code == `SAFE_PATH_FULL);
    end
  endfunction

  function path_is_tia;
    input [15:0] code;
    begin
      path_is_tia = (code == `SAFE_PATH_TIA_BUF) | (code == `SAFE_PATH_TIA_NOBUF);
    end
  endfunction

  // word index from byte address
  function [7:0] word_idx;
    input [31:0] a;
    begin
      word_idx = a[9:2];
    end
  endfunction

  // read mux; unmapped reads as zero
  function [15:0] read_word;
    input [7:0] i;
    input [15:0] t;
    input [15:0] p;
    input [15:0] c;
    begin
      case (i)
        `SAFE_IDX_TRIM:   read_word = t;
        `SAFE_IDX_PATH:   read_word = p;
        `SAFE_IDX_CHGAIN: read_word = c;
        default:          read_word = 16'h0000;
      endcase
    end
  endfunction

  assign access    = hsel & hready & (htrans == `SAFE_HTRANS_NONSEQ);
  assign idx       = word_idx(haddr);
  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // address phase captures write target, read data latched for the data phase
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rdata_reg   <= 32'h00000000;
    end else begin
      wr_pend_reg <= access & hwrite;
      wr_idx_reg  <= idx;
      if (access & ~hwrite) begin
        rdata_reg <= {16'h0000, read_word(idx, slot_a_integrator_gain_trim_reg,
                      slot_a_path_connection_reg, slot_a_channel_gain_reg)}; // RULE9
      end
    end
  end

  // writes land in the data phase; upper hwdata bits are ignored
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_a_integrator_gain_trim_reg <= `SAFE_TRIM_RST; // RULE1 RULE4 RULE5
      slot_a_path_connection_reg      <= `SAFE_PATH_RST; // RULE6
      slot_a_channel_gain_reg         <= `SAFE_CHGAIN_RST;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        `SAFE_IDX_TRIM:   slot_a_integrator_gain_trim_reg <= hwdata[15:0]; // RULE9
        `SAFE_IDX_PATH:   slot_a_path_connection_reg      <= hwdata[15:0]; // RULE6
        `SAFE_IDX_CHGAIN: slot_a_channel_gain_reg         <= {10'h000, hwdata[5:0]};
        default: begin
        end
      endcase
    end
  end

  // static levels straight from the stored fields
  assign slot_a_integrator_buffer_select =
    slot_a_integrator_gain_trim_reg[`SAFE_BIT_INT_BUF]; // RULE1
  assign slot_a_per_channel_gain_enable  =
    slot_a_integrator_gain_trim_reg[`SAFE_BIT_IND_EN]; // RULE2
  assign slot_a_transimpedance_reference =
    slot_a_integrator_gain_trim_reg[`SAFE_VREF_HI:`SAFE_VREF_LO]; // RULE4
  assign slot_a_transimpedance_gain_code =
    slot_a_integrator_gain_trim_reg[`SAFE_GAIN_HI:`SAFE_GAIN_LO]; // RULE5
  assign slot_a_integrator_mode      = slot_a_integrator_gain_trim_reg[15:10];
  assign slot_a_integrator_gain      = slot_a_integrator_gain_trim_reg[9:8];
  assign slot_a_path_connection_code = slot_a_path_connection_reg; // RULE6

  // value the path register takes at the coming edge
  always @* begin
    slot_a_path_connection_next = slot_a_path_connection_reg;
    if (wr_pend_reg && (wr_idx_reg == `SAFE_IDX_PATH)) begin
      slot_a_path_connection_next = hwdata[15:0];
    end
  end

  // flags registered with the code so they never glitch on the analog side;
  // software owns keeping the buffer bit consistent, only flagged here
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_mode_reg <= `SAFE_FULL_FLAG_RST; // RULE6
      tia_mode_reg  <= `SAFE_TIA_FLAG_RST;
      rsvd_reg      <= `SAFE_RSVD_FLAG_RST;
    end else begin
      full_mode_reg <= path_is_full(slot_a_path_connection_next); // RULE6
      tia_mode_reg  <= path_is_tia(slot_a_path_connection_next); // RULE7 RULE8
      rsvd_reg      <= ~path_is_full(slot_a_path_connection_next) &
                       ~path_is_tia(slot_a_path_connection_next);
    end
  end

  assign full_analog_path_mode = full_mode_reg;
  assign slot_a_tia_adc_mode   = tia_mode_reg;
  assign slot_a_path_reserved  = rsvd_reg;

  // channel gain source selection
  safe_gain_sel u_gain_sel (
    .per_channel_en (slot_a_per_channel_gain_enable),
    .common_gain    (slot_a_transimpedance_gain_code),
    .channel_gains  (slot_a_channel_gain_reg[5:0]),
    .gain_codes     (slot_a_channel_gain_codes)
  ); // RULE2 RULE3
endmodule // safe_regs

// *** tb/safe_regs_asserts.sv ***
`timescale 1ns/1ps
module safe_regs_asserts (
  input wire        ref_clk,
  input wire        rst,
  input wire        slot_a_integrator_buffer_select,
  input wire        slot_a_per_channel_gain_enable,
  input wire [1:0]  slot_a_transimpedance_reference,
  input wire [1:0]  slot_a_transimpedance_gain_code,
  input wire [7:0]  slot_a_channel_gain_codes,
  input wire [15:0] slot_a_path_connection_code,
  input wire        full_analog_path_mode,
  input wire        slot_a_tia_adc_mode,
  input wire        slot_a_path_reserved
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // defaults on the first edge out of reset, decoded levels at every edge after
  reset_trim_a: assert property ($fell(rst) |-> !slot_a_integrator_buffer_select &&
    slot_a_transimpedance_reference == 2'h3) else $error("trim default");
  reset_gain_a: assert property ($fell(rst) |-> slot_a_transimpedance_gain_code == 2'h0)
    else $error("gain default");
  reset_path_a: assert property ($fell(rst) |-> slot_a_path_connection_code == 16'hADA5)
    else $error("path default");
  ch1_gain_a: assert property (
    slot_a_channel_gain_codes[1:0] == slot_a_transimpedance_gain_code) else $error("ch1 gain");
  shared_gain_a: assert property (!slot_a_per_channel_gain_enable |->
    slot_a_channel_gain_codes[7:2] == {3{slot_a_transimpedance_gain_code}}) else $error("shared");
  tia_mode_a: assert property (
    slot_a_tia_adc_mode == (slot_a_path_connection_code inside {16'hAE65, 16'hB065}))
    else $error("tia mode");
  path_reserved_a: assert property (
    slot_a_path_reserved == !(full_analog_path_mode || slot_a_tia_adc_mode)) else $error("rsvd");
endmodule // safe_regs_asserts
bind safe_regs safe_regs_asserts u_safe_regs_asserts (.*);

// *** tb/slot_a_frontend_config_regs_bench.sv ***
`timescale 1ns/1ps
`include "safe_regs_map.vh"
module slot_a_frontend_config_regs_bench;
  logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] rdat;
  wire         hready;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, full_analog_path_mode, slot_a_tia_adc_mode;
  wire         slot_a_path_reserved, slot_a_integrator_buffer_select, slot_a_per_channel_gain_enable;
  wire  [1:0]  slot_a_transimpedance_reference, slot_a_transimpedance_gain_code;
  wire  [1:0]  slot_a_integrator_gain;
  wire  [7:0]  slot_a_channel_gain_codes;
  wire  [5:0]  slot_a_integrator_mode;
  wire  [15:0] slot_a_path_connection_code;
  int          errors = 0, n_checks = 0, cyc = 0;
  logic [15:0] codes [4] = '{16'hADA5, 16'hAE65, 16'hB065, 16'h1234};
  assign hready = hreadyout;
  safe_regs u_safe_regs (.*);
  always #2 ref_clk = ~ref_clk;
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; each phase is held until hready is seen high
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 22'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    @(negedge ref_clk);
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk("hrdata", rdat, exp);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard; the sequence needs a few hundred cycles at most
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`SAFE_IDX_TRIM, 32'h1C38);
    chk("vref", slot_a_transimpedance_reference, 2'h3);
    chk("imode", slot_a_integrator_mode, 6'h07);
    chk("igain", slot_a_integrator_gain, 2'h0);
    chk("perch", slot_a_per_channel_gain_enable, 1'h0);
    chk("hresp", hresp, 1'h0);
    chk("full", full_analog_path_mode, 1'h1);
    $display("defaults done");
    // every gain and reference code, junk in the upper half must be dropped
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, `SAFE_IDX_TRIM, {16'hFFFF, 16'h1C08} | (g * 32'h11));
      rd(`SAFE_IDX_TRIM, 32'h1C08 | (g * 32'h11));
      chk("gains", slot_a_channel_gain_codes, {4{g[1:0]}});
      chk("vref", slot_a_transimpedance_reference, g);
    end
    xfer(1'b1, `SAFE_IDX_CHGAIN, 32'h39);
    xfer(1'b1, `SAFE_IDX_TRIM, 32'h1CF2);
    chk("gains", slot_a_channel_gain_codes, 8'hE6);
    chk("buffer", slot_a_integrator_buffer_select, 1'b1);
    chk("perch", slot_a_per_channel_gain_enable, 1'h1);
    $display("gain done");
    // each documented path code plus a reserved one, then an unmapped slot
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `SAFE_IDX_PATH, {16'h0, codes[i]});
      rd(`SAFE_IDX_PATH, {16'h0, codes[i]});
      chk("code", slot_a_path_connection_code, codes[i]);
      chk("full", full_analog_path_mode, i == 0);
      chk("tia", slot_a_tia_adc_mode, i == 1 || i == 2);
      chk("rsvd", slot_a_path_reserved, i == 3);
    end
    xfer(1'b1, 8'h10, 32'hFFFF);
    rd(8'h10, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`SAFE_IDX_PATH, 32'hADA5);
    $display("path done");
    give_verdict;
  end
endmodule // slot_a_frontend_config_regs_bench
